// ### common/crpc_params.svh
`ifndef CRPC_PARAMS_SVH
`define CRPC_PARAMS_SVH

// ==========================================================================
// Command slot of the role register.
// ==========================================================================
`define CRPC_CMD_ROLE        8'hD0

// ==========================================================================
// Role encodings and the reset value of the role register.
// ==========================================================================
`define CRPC_ROLE_STD        8'h00
`define CRPC_ROLE_ACTIVE     8'h01
`define CRPC_ROLE_STBY1      8'h02
`define CRPC_ROLE_STBY2      8'h03
`define CRPC_ROLE_STBY3      8'h04
`define CRPC_ROLE_ALWAYS     8'h05
`define CRPC_ROLE_RESET      `CRPC_ROLE_STD

// ==========================================================================
// Load-share scale and per-position thresholds, in millivolts.
// ==========================================================================
`define CRPC_SHARE_FULL_MV   8000
`define CRPC_EN1_MV          3200
`define CRPC_EN2_MV          5000
`define CRPC_EN3_MV          6700
`define CRPC_DIS1_MV         1440
`define CRPC_DIS2_MV         3010
`define CRPC_DIS3_MV         4520

// ==========================================================================
// Timing.
// ==========================================================================
`define CRPC_TURN_ON_MAX_NS  100000
`define CRPC_CLK_PERIOD_NS   40

// ==========================================================================
// One-hot converter state codes.
// ==========================================================================
`define CRPC_CNV_RUN         2'h1
`define CRPC_CNV_STBY        2'h2

`endif

// ### common/crpc_pkg.sv
package crpc_pkg;
  `include "crpc_params.svh"

  // Programmed role of this supply within the redundant group.
  typedef enum logic [7:0] {
    CRPC_ROLE_STD    = `CRPC_ROLE_STD,
    CRPC_ROLE_ACTIVE = `CRPC_ROLE_ACTIVE,
    CRPC_ROLE_STBY1  = `CRPC_ROLE_STBY1,
    CRPC_ROLE_STBY2  = `CRPC_ROLE_STBY2,
    CRPC_ROLE_STBY3  = `CRPC_ROLE_STBY3,
    CRPC_ROLE_ALWAYS = `CRPC_ROLE_ALWAYS
  } crpc_role_type;

  // Main converter state, one-hot.
  typedef enum logic [1:0] {
    CRPC_RUN  = `CRPC_CNV_RUN,
    CRPC_STBY = `CRPC_CNV_STBY
  } crpc_cnv_type;
endpackage

// ### dv/crpc_peer_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Other supplies on the shared standby line, and the load-share comparators.
// ==========================================================================
module crpc_peer_model #(
  parameter int DAC_W = 8
) (
  input  wire logic             dut_oe,
  input  wire logic             dut_o,
  input  wire logic             peer_active,
  input  wire logic             peer_fault,
  input  wire logic [15:0]      share_mv,
  input  wire logic [DAC_W-1:0] en_ref,
  input  wire logic [DAC_W-1:0] dis_ref,
  output logic                  line,
  output logic                  above_en,
  output logic                  above_dis
);
  localparam int FULL_MV  = 8000;              // Share level at full rated power.
  localparam int CODE_MAX = (1 << DAC_W) - 1;  // Reference code at full scale.

  // A low driver always wins.
  // The board pull-down sets the line low when nobody drives it high.
  always_comb begin
    if ((dut_oe && !dut_o) || peer_fault) begin
      line = 1'b0;
    end else if ((dut_oe && dut_o) || peer_active) begin
      line = 1'b1;
    end else begin
      line = 1'b0;
    end
  end

  // The comparators scale each reference code against full scale.
  always_comb begin
    above_en  = int'(share_mv) * CODE_MAX > int'(en_ref) * FULL_MV;
    above_dis = int'(share_mv) * CODE_MAX > int'(dis_ref) * FULL_MV;
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", name, exp, got); end end
// ==========================================================================
// Self-checking bench for the standby power control.
// ==========================================================================
module tb_top;
  import crpc_pkg::*;
  localparam int DAC_W = 8;
  logic             clk, srst, cmd_valid, cmd_write, cmd_pec_ok, cmd_hit, cmd_ack, cmd_nak;
  logic [7:0]       cmd_code, cmd_wdata, cmd_rdata;
  logic             supply_fault, vout_low_fault, line, line_o, line_oe, above_en, above_dis;
  logic [DAC_W-1:0] en_lvl, dis_lvl;
  logic             converter_on_n, main_converter_en, peer_active, peer_fault;
  logic [15:0]      share_mv;
  int               n_mismatch, num_checks, cycles;
  int               en_mv[3]  = '{3200, 5000, 6700};  // Enable levels of positions one to three.
  int               dis_mv[3] = '{1440, 3010, 4520};  // Disable levels, below enable for hysteresis.

  crpc_ctrl #(.DAC_W(DAC_W)) i_dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_pec_ok(cmd_pec_ok), .cmd_hit(cmd_hit), .cmd_ack(cmd_ack),
    .cmd_nak(cmd_nak), .cmd_rdata(cmd_rdata), .supply_fault(supply_fault), .vout_low_fault(vout_low_fault),
    .shared_standby_line_i(line), .shared_standby_line_o(line_o), .shared_standby_line_oe(line_oe),
    .share_above_en(above_en), .share_above_dis(above_dis), .share_enable_level(en_lvl),
    .share_disable_level(dis_lvl), .converter_on_n(converter_on_n), .main_converter_en(main_converter_en));

  crpc_peer_model #(.DAC_W(DAC_W)) i_peer (.dut_oe(line_oe), .dut_o(line_o), .peer_active(peer_active),
    .peer_fault(peer_fault), .share_mv(share_mv), .en_ref(en_lvl), .dis_ref(dis_lvl), .line(line),
    .above_en(above_en), .above_dis(above_dis));

  // ==========================================================================
  // Clock and hang guard; the run needs well under two thousand cycles.
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================================
  // Tasks.
  // ==========================================================================
  // One command, strobed for one cycle; the answer flags are combinational.
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [7:0] data, input logic pec,
                     input logic exp_hit, input logic exp_ack);
    @(posedge clk);
    #1;
    cmd_valid  = 1'b1;
    cmd_write  = wr;
    cmd_code   = code;
    cmd_wdata  = data;
    cmd_pec_ok = pec;
    #5;
    `CHK("cmd_hit", exp_hit, cmd_hit)
    `CHK("cmd_ack", exp_ack, cmd_ack)
    `CHK("cmd_nak", exp_hit & ~exp_ack, cmd_nak)
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask

  // Read data is captured at the edge that takes the read.
  task automatic read_role(input logic [7:0] exp);
    cmd(1'b0, 8'hD0, 8'h00, 1'b1, 1'b1, 1'b1);
    `CHK("cmd_rdata", exp, cmd_rdata)
  endtask

  // Synchronisers need about five edges; ten leaves margin yet stays far inside the turn-on bound.
  task automatic chk_conv(input logic exp_off);
    repeat (10) @(posedge clk);
    #1;
    `CHK("converter_on_n", exp_off, converter_on_n)
    `CHK("main_converter_en", ~exp_off, main_converter_en)
  endtask

  task automatic finish_test();
    $display("Checks: %0d, mismatches: %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    {cmd_valid, cmd_write, cmd_pec_ok, supply_fault, vout_low_fault, peer_fault} = '0;
    cmd_code    = 8'h00;
    cmd_wdata   = 8'h00;
    share_mv    = 16'h0000;
    peer_active = 1'b1;  // A peer holds the line high so the group may idle.
    srst        = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    `CHK("converter_on_n", 1'b0, converter_on_n)
    `CHK("line_oe", 1'b0, line_oe)
    read_role(8'h00);
    for (int r = 0; r < 6; r++) begin
      cmd(1'b1, 8'hD0, 8'(r), 1'b1, 1'b1, 1'b1);
      read_role(8'(r));
    end
    cmd(1'b1, 8'hD0, 8'h06, 1'b1, 1'b1, 1'b0);
    cmd(1'b1, 8'hD0, 8'h02, 1'b0, 1'b1, 1'b0);
    cmd(1'b1, 8'hD1, 8'h02, 1'b1, 1'b0, 1'b0);
    read_role(8'h05);
    // Always standby ignores even a heavy load.
    share_mv = 16'd7000;
    chk_conv(1'b1);
    // Each standby position, walked through its hysteresis band.
    for (int p = 0; p < 3; p++) begin
      share_mv = 16'd0;
      cmd(1'b1, 8'hD0, 8'(p + 2), 1'b1, 1'b1, 1'b1);
      chk_conv(1'b1);
      `CHK("share_enable_level", DAC_W'(en_mv[p] * 255 / 8000), en_lvl)
      `CHK("share_disable_level", DAC_W'(dis_mv[p] * 255 / 8000), dis_lvl)
      share_mv = 16'(en_mv[p] + 100);
      chk_conv(1'b0);
      share_mv = 16'((en_mv[p] + dis_mv[p]) / 2);
      chk_conv(1'b0);
      share_mv = 16'(dis_mv[p] - 100);
      chk_conv(1'b1);
    end
    // Standard and active roles always run; only the active role drives high.
    cmd(1'b1, 8'hD0, 8'h00, 1'b1, 1'b1, 1'b1);
    chk_conv(1'b0);
    `CHK("line_oe", 1'b0, line_oe)
    cmd(1'b1, 8'hD0, 8'h01, 1'b1, 1'b1, 1'b1);
    chk_conv(1'b0);
    `CHK("line_oe", 1'b1, line_oe)
    `CHK("line_o", 1'b1, line_o)
    // Own faults pull the line low.
    supply_fault = 1'b1;
    chk_conv(1'b0);
    `CHK("line_o", 1'b0, line_o)
    `CHK("line_oe", 1'b1, line_oe)
    supply_fault   = 1'b0;
    vout_low_fault = 1'b1;
    chk_conv(1'b0);
    `CHK("line_o", 1'b0, line_o)
    `CHK("line_oe", 1'b1, line_oe)
    vout_low_fault = 1'b0;
    // A peer fault wakes a standby supply and clears its role.
    share_mv = 16'd0;
    cmd(1'b1, 8'hD0, 8'h03, 1'b1, 1'b1, 1'b1);
    chk_conv(1'b1);
    peer_fault = 1'b1;
    chk_conv(1'b0);
    read_role(8'h00);
    peer_fault = 1'b0;
    cmd(1'b1, 8'hD0, 8'h03, 1'b1, 1'b1, 1'b1);
    chk_conv(1'b1);
    // With nobody driving high the pull-down wins and everyone runs.
    peer_active = 1'b0;
    chk_conv(1'b0);
    read_role(8'h00);
    finish_test();
  end
endmodule

// ### src/crpc_ctrl.sv
`timescale 1ns/1ns
// What this block does
// RULE1: Fault or low output pulls shared line low.
// RULE2: Standby supply runs when shared line low.
// RULE3: No active driver high: every supply runs.
// RULE4: Starts as always on before programming.
// RULE5: Standby allowed only with active or standard peer.
// RULE6: Stay off only: line high, share low.
// RULE7: Standby position selects load-share thresholds.
// RULE8: Enable/disable thresholds per position with hysteresis.
// RULE9: Thresholds scaled to 8.0V full scale.
// RULE10: Standard and active roles always run.
// RULE11: Active drives high; others float; fault low.
// RULE12: Converter on within 100 us of line low.
// RULE13: Role written by read/write byte D0h.
// RULE14: Role codes 00h to 05h as defined.
// RULE15: Role register resets to standard redundancy.
// RULE16: Always-standby role ignores load level.
// RULE17: Line falling edge resets standby roles.
// RULE18: Host must rewrite role after fault event.
// RULE19: Synchronise inputs; detect edge after sync.
module crpc_ctrl #(
  parameter int DAC_W = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  // Command port from the management bus engine.
  input  wire logic             cmd_valid,
  input  wire logic             cmd_write,
  input  wire logic [7:0]       cmd_code,
  input  wire logic [7:0]       cmd_wdata,
  input  wire logic             cmd_pec_ok,
  output logic                  cmd_hit,
  output logic                  cmd_ack,
  output logic                  cmd_nak,
  output logic      [7:0]       cmd_rdata,
  // Supply health, from outside the clock domain.
  input  wire logic             supply_fault,
  input  wire logic             vout_low_fault,
  // Shared standby line, a wired bus between the supplies.
  input  wire logic             shared_standby_line_i,
  output logic                  shared_standby_line_o,
  output logic                  shared_standby_line_oe,
  // Load-share comparator flags and their references.
  input  wire logic             share_above_en,
  input  wire logic             share_above_dis,
  output logic      [DAC_W-1:0] share_enable_level,
  output logic      [DAC_W-1:0] share_disable_level,
  // Converter control.
  output logic                  converter_on_n,
  output logic                  main_converter_en
);
  import crpc_pkg::*;
  `include "crpc_params.svh"

  // All checks in this module share one clock and sleep during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Reference codes need four to sixteen bits.
  if (DAC_W < 4 || DAC_W > 16) begin : g_bad_dac
    $error("crpc_ctrl needs DAC_W from 4 to 16.");
  end

  // ========================================================================
  // Constants and helpers.
  // ========================================================================

  // Longest permitted turn-on delay in clock cycles, rounded down.
  localparam int TURN_ON_CYCLES = `CRPC_TURN_ON_MAX_NS / `CRPC_CLK_PERIOD_NS;

  // The turn-on watchdog below counts in twelve bits.
  if (TURN_ON_CYCLES > 4095) begin : g_bad_turn_on
    $error("crpc_ctrl turn-on bound does not fit its counter.");
  end

  // True for every role that may park the converter.
  function automatic logic is_standby(input logic [7:0] role);
    return role >= `CRPC_ROLE_STBY1 && role <= `CRPC_ROLE_ALWAYS;
  endfunction

  // Standby position one to three, zero for any other role.
  function automatic logic [1:0] standby_pos(input logic [7:0] role);
    case (role)
      `CRPC_ROLE_STBY1: return 2'h1;
      `CRPC_ROLE_STBY2: return 2'h2;
      `CRPC_ROLE_STBY3: return 2'h3;
      default:          return 2'h0;
    endcase
  endfunction

  // ========================================================================
  // Input synchronisation.
  // ========================================================================

  logic [4:0]    sync_bits;      // Synchronised input bundle.
  logic          fault_s;        // Local supply fault.
  logic          vout_low_s;     // Output below the fault threshold.
  logic          line_s;         // Shared line level.
  logic          above_en_s;     // Share above the enable reference.
  logic          above_dis_s;    // Share above the disable reference.
  logic          line_prev_q;    // Previous synchronised line level.
  logic          line_fall;      // Falling edge of the shared line.
  logic          any_fault;      // Reason to pull the line low.
  crpc_role_type role_q;         // Role register.
  crpc_cnv_type  cnv_q;          // Converter state.
  crpc_cnv_type  cnv_d;          // Next converter state.
  logic          share_high;     // Load share above the on threshold.
  logic          role_wr;        // Accepted role write.
  logic          data_ok;        // Write data is a defined role.

  // The line resets high so release from reset cannot fake a falling edge.
  crpc_sync3 #(
    .WIDTH   (5),
    .RST_VAL (5'h04)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({share_above_dis,
                share_above_en,
                shared_standby_line_i,
                vout_low_fault,
                supply_fault}),
    .sync_q   (sync_bits)
  );

  assign fault_s     = sync_bits[0]; // RULE19
  assign vout_low_s  = sync_bits[1];
  assign line_s      = sync_bits[2]; // RULE19
  assign above_en_s  = sync_bits[3];
  assign above_dis_s = sync_bits[4];
  assign any_fault   = fault_s | vout_low_s;

  // Edge detection looks only at the synchronised level.
  always_ff @(posedge clk) begin
    if (srst) begin
      line_prev_q <= 1'b1;
    end else begin
      line_prev_q <= line_s;
    end
  end

  assign line_fall = line_prev_q & ~line_s; // RULE19

  // ========================================================================
  // Role register and command port.
  // ========================================================================

  assign data_ok = cmd_wdata <= `CRPC_ROLE_ALWAYS;                       // RULE14
  assign cmd_hit = cmd_valid & (cmd_code == `CRPC_CMD_ROLE);             // RULE13
  // Reads always succeed; writes need good packet check and a defined role.
  assign cmd_ack = cmd_hit & (~cmd_write | (cmd_pec_ok & data_ok));      // RULE13
  assign cmd_nak = cmd_hit & ~cmd_ack;
  assign role_wr = cmd_hit & cmd_write & cmd_pec_ok & data_ok;

  // A falling edge wins over a same-cycle host write, so the group never
  // loses the forced return to standard redundancy.
  always_ff @(posedge clk) begin
    if (srst) begin
      role_q <= crpc_role_type'(`CRPC_ROLE_RESET);                       // RULE15
    end else if (line_fall && is_standby(role_q)) begin
      role_q <= CRPC_ROLE_STD;                                           // RULE17
    end else if (role_wr) begin
      role_q <= crpc_role_type'(cmd_wdata);                              // RULE14
    end
  end

  // Read data is captured on an accepted read and held until the next one.
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_rdata <= 8'h00;
    end else if (cmd_hit && !cmd_write) begin
      cmd_rdata <= role_q;
    end
  end

  // ========================================================================
  // Load-share thresholds.
  // ========================================================================

  crpc_share_thresh #(
    .DAC_W (DAC_W)
  ) u_thresh (
    .clk          (clk),
    .srst         (srst),
    .position     (standby_pos(role_q)),
    .above_en     (above_en_s),
    .above_dis    (above_dis_s),
    .en_ref_q     (share_enable_level),
    .dis_ref_q    (share_disable_level),
    .share_high_q (share_high)
  );

  // ========================================================================
  // Shared line drive.
  // ========================================================================

  // A fault pulls low in any role; a healthy active supply holds the line
  // high; everyone else floats. The floating case relies on the board
  // pulling the line low when nobody drives it high.
  always_ff @(posedge clk) begin
    if (srst) begin
      shared_standby_line_oe <= 1'b0;
      shared_standby_line_o  <= 1'b0;
    end else if (any_fault) begin
      shared_standby_line_oe <= 1'b1;                                    // RULE1
      shared_standby_line_o  <= 1'b0;                                    // RULE11
    end else begin
      shared_standby_line_oe <= (role_q == CRPC_ROLE_ACTIVE);            // RULE11
      shared_standby_line_o  <= (role_q == CRPC_ROLE_ACTIVE);
    end
  end

  // ========================================================================
  // Converter state.
  // ========================================================================

  // Parking is only possible while the line is high, which means some
  // active peer keeps the group alive.
  always_comb begin
    cnv_d = CRPC_RUN;                                                    // RULE4
    case (cnv_q)
      CRPC_RUN, CRPC_STBY: begin
        if (is_standby(role_q) && line_s) begin                          // RULE5 RULE3
          if (role_q == CRPC_ROLE_ALWAYS || !share_high) begin           // RULE16
            cnv_d = CRPC_STBY;                                           // RULE6
          end
        end
        // A low line, or a fixed role, always leaves the converter running.
      end
      default: cnv_d = CRPC_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnv_q <= CRPC_RUN;                                                 // RULE4
    end else begin
      cnv_q <= cnv_d;                                                    // RULE2
    end
  end

  // Both outputs are state flop bits; converter_on_n is low from the cycle after a fixed role lands.
  assign converter_on_n    = cnv_q[1];                                   // RULE10
  assign main_converter_en = cnv_q[0];                                   // RULE12

  // ========================================================================
  // Checks.
  // ========================================================================

  logic [11:0] wait_cnt_q;  // Cycles parked while the line pin is low.

  // Counted from the pin, so synchroniser delay is part of the bound.
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_cnt_q <= 12'h000;
    end else if (!shared_standby_line_i && converter_on_n) begin
      wait_cnt_q <= wait_cnt_q + 12'h001;
    end else begin
      wait_cnt_q <= 12'h000;
    end
  end

  // An own fault drives the line low.
  AST_FAULT_PULLS_LOW: assert property ( // RULE1
    any_fault
    |=> shared_standby_line_oe && !shared_standby_line_o)
    else $error("Fault did not pull the shared line low.");

  // A low line wakes a parked supply.
  AST_LINE_LOW_RUNS: assert property ( // RULE2
    !line_s
    |=> main_converter_en && !converter_on_n)
    else $error("Converter parked while the line was low.");

  // With nobody holding the line up, all run.
  AST_NO_DRIVER_ALL_RUN: assert property ( // RULE3
    !line_s [*2]
    |-> main_converter_en)
    else $error("Converter off with no active driver.");

  // Reset leaves the supply running.
  AST_RESET_ALWAYS_ON: assert property ( // RULE4
    $fell(srst)
    |-> main_converter_en && role_q == CRPC_ROLE_STD)
    else $error("Not always on after reset.");

  // Parking needs a high line and either a light load or the always-standby role.
  AST_PARK_CAUSE: assert property ( // RULE6
    $rose(converter_on_n)
    |-> $past(line_s) && ($past(role_q) == CRPC_ROLE_ALWAYS || !$past(share_high)))
    else $error("Converter parked without cause.");

  // Fixed roles never park.
  AST_FIXED_ROLE_RUNS: assert property ( // RULE10
    role_q inside {CRPC_ROLE_STD, CRPC_ROLE_ACTIVE}
    |=> main_converter_en)
    else $error("Fixed role stopped its converter.");

  // A healthy active supply holds the line up.
  AST_ACTIVE_DRIVES_HIGH: assert property ( // RULE11
    role_q == CRPC_ROLE_ACTIVE && !any_fault
    |=> shared_standby_line_oe && shared_standby_line_o)
    else $error("Healthy active role not driving high.");

  // Healthy passive roles let go of the line.
  AST_OTHERS_FLOAT: assert property ( // RULE11
    role_q != CRPC_ROLE_ACTIVE && !any_fault
    |=> !shared_standby_line_oe)
    else $error("Healthy passive role driving the line.");

  // Turn-on stays inside its time bound.
  AST_TURN_ON_BOUND: assert property ( // RULE12
    wait_cnt_q < 12'(TURN_ON_CYCLES))
    else $error("Turn-on took too long.");

  // Undefined roles are refused; a same-cycle edge may still clear.
  AST_BAD_ROLE_NAK: assert property ( // RULE14
    cmd_hit && cmd_write && cmd_wdata > `CRPC_ROLE_ALWAYS && !(line_fall && is_standby(role_q))
    |-> cmd_nak ##1 $stable(role_q))
    else $error("Undefined role accepted.");

  // Always standby parks whenever the line allows.
  AST_ALWAYS_STBY_PARKS: assert property ( // RULE16
    role_q == CRPC_ROLE_ALWAYS && line_s
    |=> converter_on_n)
    else $error("Always-standby role did not park.");

  // A falling line drops standby roles.
  AST_FALL_RESETS_ROLE: assert property ( // RULE17
    line_fall && is_standby(role_q)
    |=> role_q == CRPC_ROLE_STD)
    else $error("Falling edge did not reset the role.");

  // A good write lands unless an edge wins.
  AST_WRITE_LANDS: assert property ( // RULE13
    role_wr && !(line_fall && is_standby(role_q))
    |=> role_q == $past(cmd_wdata))
    else $error("Role write did not land.");

  // A read returns the role held at the read.
  AST_READ_RETURNS_ROLE: assert property ( // RULE13
    cmd_hit && !cmd_write
    |=> cmd_rdata == $past(role_q))
    else $error("Read data does not match the role.");

  // Main scenarios that a run should reach.
  COV_ROLE_WRITE: cover property (role_wr ##1 role_q == CRPC_ROLE_STBY1);
  COV_PARK: cover property ($rose(converter_on_n));
  COV_FALL_WAKE: cover property (converter_on_n ##1 line_fall ##[1:4] main_converter_en);
  COV_FAULT_DRIVE: cover property (any_fault ##1 shared_standby_line_oe);
  COV_BAD_ROLE: cover property (cmd_nak);
endmodule

// ### src/crpc_share_thresh.sv
`timescale 1ns/1ns
// ==========================================================================
// Load-share threshold references and hysteresis for the standby positions.
// ==========================================================================
module crpc_share_thresh #(
  parameter int DAC_W = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [1:0]       position,
  input  wire logic             above_en,
  input  wire logic             above_dis,
  output logic      [DAC_W-1:0] en_ref_q,
  output logic      [DAC_W-1:0] dis_ref_q,
  output logic                  share_high_q
);
  import crpc_pkg::*;
  `include "crpc_params.svh"

  if (DAC_W < 4 || DAC_W > 16) begin : g_bad_dac
    $error("crpc_share_thresh needs DAC_W from 4 to 16.");
  end

  // Scales a level in millivolts against the full-scale share voltage.
  function automatic logic [DAC_W-1:0] mv_to_code(input int unsigned mv);
    int unsigned full;
    full = (32'd1 << DAC_W) - 32'd1;
    return DAC_W'((mv * full) / `CRPC_SHARE_FULL_MV);
  endfunction

  // Reference codes follow the programmed position; unused positions park at zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      en_ref_q  <= '0;
      dis_ref_q <= '0;
    end else begin
      case (position)
        2'h1: begin
          en_ref_q  <= mv_to_code(`CRPC_EN1_MV);  // RULE7
          dis_ref_q <= mv_to_code(`CRPC_DIS1_MV); // RULE8
        end
        2'h2: begin
          en_ref_q  <= mv_to_code(`CRPC_EN2_MV);  // RULE7
          dis_ref_q <= mv_to_code(`CRPC_DIS2_MV); // RULE9
        end
        2'h3: begin
          en_ref_q  <= mv_to_code(`CRPC_EN3_MV);
          dis_ref_q <= mv_to_code(`CRPC_DIS3_MV);
        end
        default: begin
          en_ref_q  <= '0;
          dis_ref_q <= '0;
        end
      endcase
    end
  end

  // Hysteresis: set above the enable level, clear below the disable level or when no position is selected.
  always_ff @(posedge clk) begin
    if (srst) begin
      share_high_q <= 1'b0;
    end else if (position == 2'h0) begin
      share_high_q <= 1'b0;
    end else if (above_en) begin
      share_high_q <= 1'b1;                      // RULE8
    end else if (!above_dis) begin
      share_high_q <= 1'b0;                      // RULE8
    end
  end

  AST_POS1_REFS: assert property (@(posedge clk) disable iff (srst)
    position == 2'h1 |=> en_ref_q == mv_to_code(`CRPC_EN1_MV) && dis_ref_q == mv_to_code(`CRPC_DIS1_MV)) // RULE7
    else $error("Position one references wrong.");
endmodule

// ### src/crpc_sync3.sv
`timescale 1ns/1ns
// ==========================================================================
// Three-stage synchroniser; the output follows once stages two and three agree.
// ==========================================================================
module crpc_sync3 #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_q
);
  import crpc_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("crpc_sync3 needs WIDTH of at least one.");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_q;  // First stage, read only by the second stage.
    logic s2_q;  // Second stage.
    logic s3_q;  // Third stage.

    // Shift chain; the agreement check filters a single-cycle glitch.
    always_ff @(posedge clk) begin
      if (srst) begin
        s1_q      <= RST_VAL[i];
        s2_q      <= RST_VAL[i];
        s3_q      <= RST_VAL[i];
        sync_q[i] <= RST_VAL[i];
      end else begin
        s1_q <= async_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          sync_q[i] <= s3_q;
        end
      end
    end
  end
endmodule
